// [ncs_consts.vh]
// Constants for the oscillator channel-select and tuning register bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef NCS_CONSTS_VH
`define NCS_CONSTS_VH

// Register indexes; byte address is four times the index
`define NCS_IDX_OSC_CTRL 14'h0334
`define NCS_IDX_PH_CTRL 14'h0335
`define NCS_IDX_STEP0 14'h0336
`define NCS_IDX_STEP1 14'h0337
`define NCS_IDX_UPD_CTRL 14'h0380
`define NCS_IDX_OFFS0 14'h0381
`define NCS_IDX_OFFS1 14'h0382
`define NCS_IDX_STATUS 14'h0383
`define NCS_IDX_ENTRY 14'h0384

// Field positions
`define NCS_MODE_HI 7
`define NCS_MODE_LO 4
`define NCS_SEL_HI 3
`define NCS_SEL_LO 0
`define NCS_UPD_XFER_BIT 0
`define NCS_UPD_GO_BIT 1

// Channel select mode codes
`define NCS_MODE_MAP 4'h0
`define NCS_MODE_PINS 4'h1
`define NCS_MODE_EDGE1 4'h8
`define NCS_MODE_EDGE2 4'hA

// Reset values
`define NCS_RST_BYTE 8'h00
`define NCS_RST_NIB 4'h0
`define NCS_RST_WORD 16'h0000
`define NCS_RST_ACC 48'h000000000000
`define NCS_RST_DATA 32'h00000000

`endif

// [ncs_chan_counter.v]
// Edge-driven oscillator channel counter with pin synchronisers.
// Assumes the two select pins are asynchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
`include "ncs_consts.vh"

module ncs_chan_counter (
	input wire pclk,
	input wire presetn,
	input wire [3:0] mode,
	input wire [3:0] limit,
	input wire pin_one,
	input wire pin_two,
	output reg [3:0] count_reg,
	output reg [1:0] pins_reg
);
	reg [1:0] meta_reg;
	reg [1:0] pins_prev_reg;
	reg [3:0] mode_prev_reg;
	reg [3:0] count_next;
	wire rise_one;
	wire rise_two;
	wire edge_hit;

	// First stage feeds only the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 2'h0;
			pins_reg <= 2'h0;
			pins_prev_reg <= 2'h0;
			mode_prev_reg <= `NCS_RST_NIB;
		end else begin
			meta_reg <= {pin_two, pin_one};
			pins_reg <= meta_reg;
			pins_prev_reg <= pins_reg;
			mode_prev_reg <= mode;
		end
	end

	assign rise_one = pins_reg[0] & ~pins_prev_reg[0];
	assign rise_two = pins_reg[1] & ~pins_prev_reg[1];
	assign edge_hit = ((mode == `NCS_MODE_EDGE1) & rise_one) |
		((mode == `NCS_MODE_EDGE2) & rise_two);

	always @* begin
		count_next = count_reg;
		if (mode != mode_prev_reg)
			count_next = `NCS_RST_NIB;
		else if (edge_hit) begin
			if (count_reg >= limit)
				count_next = `NCS_RST_NIB;
			else
				count_next = count_reg + 4'h1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_reg <= `NCS_RST_NIB;
		else
			count_reg <= count_next;
	end
endmodule
`default_nettype wire

// [ncs_top.v]
// Oscillator channel-select and tuning register bank with APB slave.
// Assumes an APB master on pclk; select pins are asynchronous.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ncs_consts.vh"

module ncs_top #(
	parameter ADDR_W = 16,
	parameter CHANNELS = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire general_pin_one,
	input wire general_pin_two,
	output reg [3:0] active_channel,
	output reg [15:0] phase_out
);
	reg [7:0] osc_channel_control_reg;
	reg [3:0] phase_update_index_reg;
	reg [7:0] phase_step_byte0_reg;
	reg [7:0] phase_step_byte1_reg;
	reg [7:0] phase_offset_byte0_reg;
	reg [7:0] phase_offset_byte1_reg;
	reg xfer_mode_reg;
	reg commit_reg;
	reg [47:0] acc_reg;
	reg [15:0] step_tab [0:CHANNELS-1];
	reg [15:0] offs_tab [0:CHANNELS-1];
	reg [31:0] rd_next;
	reg err_next;
	reg [3:0] chan_next;
	reg commit_next;

	wire [3:0] sel_mode;
	wire [3:0] sel_field;
	wire [3:0] edge_count;
	wire [1:0] pins_sync;
	wire access;
	wire wr_en;
	wire [15:0] commit_vec;
	wire [15:0] step_act;
	wire [15:0] offs_act;
	wire [47:0] acc_next;
	wire [47:0] phase_sum;

	function hit;
		input [ADDR_W-1:0] a;
		input [13:0] idx;
		begin
			hit = (a == {idx, 2'b00});
		end
	endfunction

	function mapped;
		input [ADDR_W-1:0] a;
		begin
			mapped = hit(a, `NCS_IDX_OSC_CTRL) | hit(a, `NCS_IDX_PH_CTRL) |
				hit(a, `NCS_IDX_STEP0) | hit(a, `NCS_IDX_STEP1) |
				hit(a, `NCS_IDX_UPD_CTRL) | hit(a, `NCS_IDX_OFFS0) |
				hit(a, `NCS_IDX_OFFS1) | hit(a, `NCS_IDX_STATUS) |
				hit(a, `NCS_IDX_ENTRY);
		end
	endfunction

	assign sel_mode = osc_channel_control_reg[`NCS_MODE_HI:`NCS_MODE_LO];
	assign sel_field = osc_channel_control_reg[`NCS_SEL_HI:`NCS_SEL_LO];

	// One wait state: pready rises on the second access cycle
	assign access = psel & penable;
	assign wr_en = access & pready & pwrite & pstrb[0];

	ncs_chan_counter u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.mode(sel_mode),
		.limit(sel_field),
		.pin_one(general_pin_one),
		.pin_two(general_pin_two),
		.count_reg(edge_count),
		.pins_reg(pins_sync)
	);

	// Read data and error are captured at the same edge that raises pready
	always @* begin
		rd_next = `NCS_RST_DATA;
		err_next = ~mapped(paddr);
		if (hit(paddr, `NCS_IDX_OSC_CTRL))
			rd_next[7:0] = osc_channel_control_reg;
		if (hit(paddr, `NCS_IDX_PH_CTRL))
			rd_next[3:0] = phase_update_index_reg;
		if (hit(paddr, `NCS_IDX_STEP0))
			rd_next[7:0] = phase_step_byte0_reg;
		if (hit(paddr, `NCS_IDX_STEP1))
			rd_next[7:0] = phase_step_byte1_reg;
		if (hit(paddr, `NCS_IDX_UPD_CTRL))
			rd_next[`NCS_UPD_XFER_BIT] = xfer_mode_reg;
		if (hit(paddr, `NCS_IDX_OFFS0))
			rd_next[7:0] = phase_offset_byte0_reg;
		if (hit(paddr, `NCS_IDX_OFFS1))
			rd_next[7:0] = phase_offset_byte1_reg;
		if (hit(paddr, `NCS_IDX_STATUS))
			rd_next[7:0] = {edge_count, active_channel};
		if (hit(paddr, `NCS_IDX_ENTRY))
			rd_next = {offs_tab[phase_update_index_reg], step_tab[phase_update_index_reg]};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= `NCS_RST_DATA;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			if (access & ~pready) begin
				prdata <= rd_next;
				pslverr <= err_next;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_channel_control_reg <= `NCS_RST_BYTE;
			phase_update_index_reg <= `NCS_RST_NIB;
			phase_step_byte0_reg <= `NCS_RST_BYTE;
			phase_step_byte1_reg <= `NCS_RST_BYTE;
			phase_offset_byte0_reg <= `NCS_RST_BYTE;
			phase_offset_byte1_reg <= `NCS_RST_BYTE;
			xfer_mode_reg <= 1'b0;
		end else if (wr_en) begin
			if (hit(paddr, `NCS_IDX_OSC_CTRL))
				osc_channel_control_reg <= pwdata[7:0];
			if (hit(paddr, `NCS_IDX_PH_CTRL))
				phase_update_index_reg <= pwdata[3:0];
			if (hit(paddr, `NCS_IDX_STEP0))
				phase_step_byte0_reg <= pwdata[7:0];
			if (hit(paddr, `NCS_IDX_STEP1))
				phase_step_byte1_reg <= pwdata[7:0];
			if (hit(paddr, `NCS_IDX_OFFS0))
				phase_offset_byte0_reg <= pwdata[7:0];
			if (hit(paddr, `NCS_IDX_OFFS1))
				phase_offset_byte1_reg <= pwdata[7:0];
			if (hit(paddr, `NCS_IDX_UPD_CTRL))
				xfer_mode_reg <= pwdata[`NCS_UPD_XFER_BIT];
		end
	end

	// Continuous mode commits each value write; transfer mode waits for the go bit
	always @* begin
		commit_next = 1'b0;
		if (wr_en) begin
			if (xfer_mode_reg)
				commit_next = hit(paddr, `NCS_IDX_UPD_CTRL) & pwdata[`NCS_UPD_GO_BIT];
			else
				commit_next = hit(paddr, `NCS_IDX_STEP0) | hit(paddr, `NCS_IDX_STEP1) |
					hit(paddr, `NCS_IDX_OFFS0) | hit(paddr, `NCS_IDX_OFFS1);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			commit_reg <= 1'b0;
		else
			commit_reg <= commit_next;
	end

	assign commit_vec = commit_reg ? (16'h0001 << phase_update_index_reg) : 16'h0000;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : g_tab
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					step_tab[g] <= `NCS_RST_WORD;
					offs_tab[g] <= `NCS_RST_WORD;
				end else if (commit_vec[g]) begin
					step_tab[g] <= {phase_step_byte1_reg, phase_step_byte0_reg};
					offs_tab[g] <= {phase_offset_byte1_reg, phase_offset_byte0_reg};
				end
			end
		end
	endgenerate

	always @* begin
		case (sel_mode)
			`NCS_MODE_MAP: chan_next = sel_field;
			`NCS_MODE_PINS: chan_next = {2'b00, pins_sync[1], pins_sync[0]};
			`NCS_MODE_EDGE1: chan_next = edge_count;
			`NCS_MODE_EDGE2: chan_next = edge_count;
			// Undefined modes fall back to the register field
			default: chan_next = sel_field;
		endcase
	end

	assign step_act = step_tab[active_channel];
	assign offs_act = offs_tab[active_channel];
	// Sign extension keeps negative steps tuning below zero
	assign acc_next = acc_reg + {{32{step_act[15]}}, step_act};
	assign phase_sum = acc_reg + {{32{offs_act[15]}}, offs_act};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_channel <= `NCS_RST_NIB;
			acc_reg <= `NCS_RST_ACC;
			phase_out <= `NCS_RST_WORD;
		end else begin
			active_channel <= chan_next;
			acc_reg <= acc_next;
			phase_out <= phase_sum[47:32];
		end
	end
endmodule
`default_nettype wire

// [ncs_props.sv]
// Checker on the register bank ports.
// Assumes a master that holds each request until pready.
`timescale 1ns/1ns
`default_nettype none
`include "ncs_consts.vh"
module ncs_props #(
	parameter ADDR_W = 16,
	parameter CHANNELS = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic general_pin_one,
	input wire logic general_pin_two,
	input wire logic [3:0] active_channel
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] ctl_reg;
	wire [13:0] idx = paddr[15:2];
	wire [1:0] pins = {general_pin_two, general_pin_one};
	wire [3:0] mode = ctl_reg[7:4];
	wire hit = (idx >= `NCS_IDX_OSC_CTRL && idx <= `NCS_IDX_STEP1) || (idx >= `NCS_IDX_UPD_CTRL && idx <= `NCS_IDX_ENTRY);
	// Shadow of the mode byte; strobes are all set by the bench
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) ctl_reg <= 8'h00;
		else if (psel && penable && pready && pwrite && idx == `NCS_IDX_OSC_CTRL) ctl_reg <= pwdata[7:0];
	sequence s_setup; psel && !penable; endsequence
	sequence s_acc; psel && penable; endsequence
	property p_wait; s_setup ##1 s_acc |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("late ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == !hit; endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_err_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_err_rd: assert property (p_err_rd) else $error("error read not zero");
	property p_map; (mode == `NCS_MODE_MAP && $stable(ctl_reg))[*3] |-> active_channel == ctl_reg[3:0]; endproperty
	a_map: assert property (p_map) else $error("channel not from field");
	property p_pins; (mode == `NCS_MODE_PINS && $stable(pins))[*6] |-> active_channel == {2'h0, pins}; endproperty
	a_pins: assert property (p_pins) else $error("channel not from pins");
	property p_clr; $changed(mode) && mode[3] |-> ##[1:4] active_channel == 4'h0; endproperty
	a_clr: assert property (p_clr) else $error("counter not cleared");
	property p_hold; (mode[3] && $stable(ctl_reg) && $stable(pins))[*8] |-> $stable(active_channel); endproperty
	a_hold: assert property (p_hold) else $error("count moved without edge");
endmodule
bind ncs_top ncs_props #(.ADDR_W(ADDR_W), .CHANNELS(CHANNELS)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .general_pin_one, .general_pin_two, .active_channel);
`default_nettype wire

// [ncs_pin_drv.sv]
// Model of the logic driving the two select pins.
// Assumes tasks are called from pclk-aligned code.
`timescale 1ns/1ns
`default_nettype none
module ncs_pin_drv (
	input wire logic pclk,
	output logic pin_one,
	output logic pin_two
);
	initial {pin_two, pin_one} = 2'h0;
	task automatic levels(input logic [1:0] v);
		@(posedge pclk);
		{pin_two, pin_one} <= v;
	endtask
	// Three clocks high and low, so the synchroniser cannot miss a pulse
	task automatic pulse(input logic two);
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			if (two) pin_two <= i < 3;
			else pin_one <= i < 3;
		end
	endtask
endmodule
`default_nettype wire

// [test_nco_channel_select_config.sv]
// Bench for the channel-select register bank.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "ncs_consts.vh"
module test_nco_channel_select_config;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [15:0] paddr = 16'h0000, phase_out;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic [3:0] active_channel, c;
	wire general_pin_one, general_pin_two;
	int miscompares = 0, total_checks = 0;
	always #5 pclk = ~pclk;
	ncs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .general_pin_one, .general_pin_two, .active_channel, .phase_out);
	ncs_pin_drv PIN (.pclk, .pin_one(general_pin_one), .pin_two(general_pin_two));
	task automatic end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] i, input logic [7:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'h0, 24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Ready, data and error are all taken at the edge that completes the access
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task automatic rdchk(input logic [13:0] i, input logic [31:0] e, input logic ee);
		apb(1'b0, i, 8'h00);
		chk(rd, e);
		chk({31'h0, er}, {31'h0, ee});
	endtask
	task automatic outs(input logic [3:0] a, input logic [15:0] p);
		repeat (6) @(posedge pclk);
		@(negedge pclk);
		chk({28'h0, active_channel}, {28'h0, a});
		chk({16'h0, phase_out}, {16'h0, p});
	endtask
	function automatic logic [3:0] next_cnt(input logic [3:0] n, input logic [3:0] lim);
		return (n >= lim) ? 4'h0 : n + 4'h1;
	endfunction
	initial begin
		r = $urandom(67);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++)
			rdchk(14'(`NCS_IDX_OSC_CTRL + i), 32'h0, 1'b0);
		rdchk(14'h0338, 32'h0, 1'b1);
		apb(1'b1, `NCS_IDX_PH_CTRL, 8'hFF);
		rdchk(`NCS_IDX_PH_CTRL, 32'hF, 1'b0);
		repeat (4) begin
			r = $urandom;
			apb(1'b1, `NCS_IDX_OSC_CTRL, {4'h0, r[3:0]});
			outs(r[3:0], 16'h0);
			PIN.levels(r[5:4]);
			apb(1'b1, `NCS_IDX_OSC_CTRL, 8'h10);
			outs({2'h0, r[5:4]}, 16'h0);
		end
		PIN.levels(2'h0);
		for (int k = 0; k < 2; k++) begin
			c = 4'h0;
			apb(1'b1, `NCS_IDX_OSC_CTRL, {k ? `NCS_MODE_EDGE2 : `NCS_MODE_EDGE1, 4'h2});
			outs(c, 16'h0);
			PIN.pulse(k == 0);
			outs(c, 16'h0);
			repeat (4) begin
				PIN.pulse(k != 0);
				c = next_cnt(c, 4'h2);
				outs(c, 16'h0);
			end
		end
		apb(1'b1, `NCS_IDX_PH_CTRL, 8'h05);
		apb(1'b1, `NCS_IDX_OFFS1, 8'h80);
		rdchk(`NCS_IDX_ENTRY, 32'h80000000, 1'b0);
		apb(1'b1, `NCS_IDX_OSC_CTRL, 8'h05);
		outs(4'h5, 16'hFFFF);
		apb(1'b1, `NCS_IDX_OFFS1, 8'h00);
		outs(4'h5, 16'h0);
		apb(1'b1, `NCS_IDX_UPD_CTRL, 8'h01);
		apb(1'b1, `NCS_IDX_STEP1, 8'h80);
		outs(4'h5, 16'h0);
		apb(1'b1, `NCS_IDX_UPD_CTRL, 8'h03);
		rdchk(`NCS_IDX_ENTRY, 32'h00008000, 1'b0);
		outs(4'h5, 16'hFFFF);
		end_sim();
	end
	initial begin
		#100000 miscompares++;
		end_sim();
	end
endmodule
`default_nettype wire
